// *** hdl/vpsc_top.sv ***
// Sideband control for the buffered video ports and the DisplayPort source.
// Assumes a DDC responder, capability reader and link trainer alongside on core_clk.
`timescale 1ns/1ns

module vpsc_top
(
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            nrst,
  // Register port
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  output logic                                 irq,
  // Input port pins
  output logic                                 input_buffer_drive_enable,
  output logic                                 hot_plug_assert_out,
  input  wire logic                            sink_ddc_scl_in,
  input  wire logic                            sink_ddc_sda_in,
  output logic                                 sink_ddc_sda_out,
  output logic                                 sink_ddc_sda_oe,
  input  wire logic                            cec_in,
  output logic                                 cec_out,
  output logic                                 cec_oe,
  // Output port and DisplayPort hot-plug pins
  input  wire logic                            src_hpd_in,
  input  wire logic                            dp_hpd_in,
  // DDC responder on the input port
  input  wire logic                            ddc_responder_ready,
  input  wire logic                            ddc_responder_sda_low,
  output logic                                 ddc_scl_sync,
  output logic                                 ddc_sda_sync,
  // Capability reader on the output port
  output logic                                 cap_query_start,
  input  wire logic                            cap_query_done,
  output logic                                 video_enable,
  // Link trainer
  output logic                                 dp_train_start,
  input  wire logic                            dp_train_done,
  output logic                                 dp_link_up,
  output logic [vpsc_pkg::VPSC_LINK_LANE_W-1:0] dp_lane_count,
  output logic                                 dp_rate_high
);
  import vpsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] s_lvl;
  logic [NSYNC-1:0] s_rise;
  logic [NSYNC-1:0] s_fall;

  vpsc_sync #(.W(NSYNC)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({sink_ddc_sda_in, sink_ddc_scl_in, cec_in, dp_hpd_in, src_hpd_in}),
    .level    (s_lvl),
    .rise     (s_rise),
    .fall     (s_fall)
  );

  wire src_hpd = s_lvl[0];
  wire dp_hpd  = s_lvl[1];
  wire cec_lvl = s_lvl[2];
  assign ddc_scl_sync = s_lvl[3];
  assign ddc_sda_sync = s_lvl[4];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [VPSC_CTRL_W-1:0] ctrl_r;
  logic [VPSC_LINK_W-1:0] link_r;
  logic [VPSC_EV_W-1:0]   istat_r;
  logic [VPSC_EV_W-1:0]   istat_nxt;
  logic [VPSC_EV_W-1:0]   imask_r;
  logic [31:0]            rdata_r;
  logic [31:0]            rdata_nxt;
  vpsc_src_t              src_r;
  vpsc_src_t              src_nxt;
  vpsc_dp_t               dp_r;
  vpsc_dp_t               dp_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_ctrl  = reg_wr && hit(reg_addr, VPSC_OFS_CTRL);
  wire wr_imask = reg_wr && hit(reg_addr, VPSC_OFS_IMASK);
  wire wr_link  = reg_wr && hit(reg_addr, VPSC_OFS_LINK);
  wire rd_istat = reg_rd && hit(reg_addr, VPSC_OFS_ISTAT);

  // Lane requests above the wired maximum are clamped, never stored
  wire [VPSC_LINK_LANE_W-1:0] lane_req = reg_wdata[VPSC_LINK_LANE_LSB +: VPSC_LINK_LANE_W];
  wire [VPSC_LINK_LANE_W-1:0] lane_ok  = (lane_req > VPSC_MAX_LANES) ? VPSC_MAX_LANES :
                                         (lane_req == 2'h0) ? 2'h1 : lane_req;

  wire [VPSC_ST_W-1:0] stat_live = {VPSC_TMDS_CHANNELS, 2'h0, cec_lvl, hot_plug_assert_out,
                                    dp_link_up, video_enable, dp_hpd, src_hpd};

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  wire [VPSC_EV_W-1:0] ev = {s_rise[3], s_fall[2], dp_train_done && (dp_r == VPSC_DP_TRAIN),
                             cap_query_done && (src_r == VPSC_SRC_QUERY),
                             s_fall[1], s_rise[1], s_fall[0], s_rise[0]};

  // A read clears the status, but an event in the same cycle survives
  assign istat_nxt = (rd_istat ? '0 : istat_r) | ev;
  assign irq       = |(istat_r & imask_r);

  assign rdata_nxt = !reg_rd                         ? 32'h0 :
                     hit(reg_addr, VPSC_OFS_CTRL)  ? {27'h0, ctrl_r} :
                     hit(reg_addr, VPSC_OFS_STAT)  ? {20'h0, stat_live} :
                     hit(reg_addr, VPSC_OFS_ISTAT) ? {24'h0, istat_r} :
                     hit(reg_addr, VPSC_OFS_IMASK) ? {24'h0, imask_r} :
                     hit(reg_addr, VPSC_OFS_LINK)  ? {29'h0, link_r} : 32'h0;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl_r  <= VPSC_CTRL_RST;
      link_r  <= VPSC_LINK_RST;
      istat_r <= '0;
      imask_r <= '0;
      rdata_r <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[VPSC_CTRL_W-1:0];
      if (wr_imask)
        imask_r <= reg_wdata[VPSC_EV_W-1:0];
      if (wr_link)
        link_r <= {reg_wdata[VPSC_LINK_RATE], lane_ok};
      istat_r <= istat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Input port: buffer enable, hot-plug assert, DDC slave, CEC
  assign input_buffer_drive_enable = ctrl_r[VPSC_CTRL_DRV_EN];
  // Dropping the assert the moment the responder goes away avoids a source reading junk
  assign hot_plug_assert_out = ctrl_r[VPSC_CTRL_HP_ASSERT] && ddc_responder_ready;
  // As a slave the sink never drives SCL and only pulls SDA low
  assign sink_ddc_sda_out = 1'b0;
  assign sink_ddc_sda_oe  = ddc_responder_sda_low;
  assign cec_out = 1'b0;
  assign cec_oe  = ctrl_r[VPSC_CTRL_CEC_LOW];

  ////////////////////////////////////////////////////////////////////////////
  // Source port: query capabilities before any video
  always_comb
  begin
    src_nxt = src_r;
    case (src_r)
      VPSC_SRC_IDLE:
        if (src_hpd && ctrl_r[VPSC_CTRL_SRC_EN])
          src_nxt = VPSC_SRC_QUERY;
      VPSC_SRC_QUERY:
        if (!src_hpd)
          src_nxt = VPSC_SRC_IDLE;
        else if (cap_query_done)
          src_nxt = VPSC_SRC_VIDEO;
      VPSC_SRC_VIDEO:
        if (!src_hpd || !ctrl_r[VPSC_CTRL_SRC_EN])
          src_nxt = VPSC_SRC_IDLE;
      default:
        src_nxt = VPSC_SRC_IDLE;
    endcase
  end

  // DisplayPort: train the link after every attach
  always_comb
  begin
    dp_nxt = dp_r;
    case (dp_r)
      VPSC_DP_IDLE:
        if (dp_hpd && ctrl_r[VPSC_CTRL_DP_EN])
          dp_nxt = VPSC_DP_TRAIN;
      VPSC_DP_TRAIN:
        if (!dp_hpd)
          dp_nxt = VPSC_DP_IDLE;
        else if (dp_train_done)
          dp_nxt = VPSC_DP_UP;
      VPSC_DP_UP:
        if (!dp_hpd || !ctrl_r[VPSC_CTRL_DP_EN])
          dp_nxt = VPSC_DP_IDLE;
      default:
        dp_nxt = VPSC_DP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      src_r <= VPSC_SRC_IDLE;
      dp_r  <= VPSC_DP_IDLE;
    end
    else
    begin
      src_r <= src_nxt;
      dp_r  <= dp_nxt;
    end
  end

  assign cap_query_start = (src_r == VPSC_SRC_IDLE) && (src_nxt == VPSC_SRC_QUERY);
  assign video_enable    = (src_r == VPSC_SRC_VIDEO);
  assign dp_train_start  = (dp_r == VPSC_DP_IDLE) && (dp_nxt == VPSC_DP_TRAIN);
  assign dp_link_up      = (dp_r == VPSC_DP_UP);
  // Lanes and rate follow link_r at once, even while the link is trained or up
  assign dp_lane_count   = link_r[VPSC_LINK_LANE_LSB +: VPSC_LINK_LANE_W];
  assign dp_rate_high    = link_r[VPSC_LINK_RATE];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_query;
    cap_query_start ##1 (src_r == VPSC_SRC_QUERY);
  endsequence

  chk_drive_en_ctrl: assert property (
    !ctrl_r[VPSC_CTRL_DRV_EN] |-> !input_buffer_drive_enable)
    else $error("buffer drive enable high without control bit");
  chk_hpa_needs_responder: assert property (
    hot_plug_assert_out |-> ddc_responder_ready && ctrl_r[VPSC_CTRL_HP_ASSERT])
    else $error("hot-plug assert without ready responder");
  chk_cec_open_drain: assert property (
    cec_oe |-> !cec_out)
    else $error("CEC driven high");
  chk_ddc_sda_slave: assert property (
    sink_ddc_sda_oe |-> !sink_ddc_sda_out && ddc_responder_sda_low)
    else $error("DDC data driven high");
  chk_query_on_hpd: assert property (
    s_query |-> $past(src_hpd, 1))
    else $error("capability query without hot-plug");
  chk_video_after_query: assert property (
    $rose(video_enable) |-> $past(src_r == VPSC_SRC_QUERY) && $past(cap_query_done))
    else $error("video enabled without capability query");
  chk_train_on_hpd: assert property (
    dp_train_start |-> dp_hpd ##1 (dp_r == VPSC_DP_TRAIN) && !dp_link_up)
    else $error("link training start not tied to hot-plug");
  chk_link_after_train: assert property (
    $rose(dp_link_up) |-> $past(dp_train_done) && $past(dp_r == VPSC_DP_TRAIN))
    else $error("link up without training");
  chk_lane_max: assert property (
    dp_lane_count <= VPSC_MAX_LANES && dp_lane_count != 2'h0)
    else $error("lane count outside one to two");
  chk_hpd_two_stage: assert property (
    $rose(src_hpd) |-> $past(src_hpd_in, 2))
    else $error("hot-plug level not delayed by two stages");
  chk_irq_sticky: assert property (
    ev[VPSC_EV_SRC_HPD_UP] |=> istat_r[VPSC_EV_SRC_HPD_UP])
    else $error("event lost from interrupt status");
endmodule : vpsc_top

// *** hdl/vpsc_pkg.sv ***
// Package for the video port sideband control block.
// Assumes a single 125 MHz core clock and a plain strobe register port.
package vpsc_pkg;
  // Register byte offsets
  localparam logic [7:0] VPSC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] VPSC_OFS_STAT  = 8'h04;
  localparam logic [7:0] VPSC_OFS_ISTAT = 8'h08;
  localparam logic [7:0] VPSC_OFS_IMASK = 8'h0c;
  localparam logic [7:0] VPSC_OFS_LINK  = 8'h10;
  // Control register fields
  localparam int VPSC_CTRL_DRV_EN    = 0;
  localparam int VPSC_CTRL_HP_ASSERT = 1;
  localparam int VPSC_CTRL_CEC_LOW = 2;
  localparam int VPSC_CTRL_SRC_EN  = 3;
  localparam int VPSC_CTRL_DP_EN   = 4;
  localparam int VPSC_CTRL_W       = 5;
  localparam logic [VPSC_CTRL_W-1:0] VPSC_CTRL_RST = 5'h00;
  // Link register fields: lane count in [1:0], rate select in [2]
  localparam int VPSC_LINK_LANE_LSB = 0;
  localparam int VPSC_LINK_LANE_W   = 2;
  localparam int VPSC_LINK_RATE     = 2;
  localparam int VPSC_LINK_W        = 3;
  localparam logic [VPSC_LINK_W-1:0] VPSC_LINK_RST = 3'h1;
  localparam logic [VPSC_LINK_LANE_W-1:0] VPSC_MAX_LANES = 2'h2;
  // Event bits shared by interrupt status and mask
  localparam int VPSC_EV_SRC_HPD_UP = 0;
  localparam int VPSC_EV_SRC_HPD_DN = 1;
  localparam int VPSC_EV_DP_HPD_UP  = 2;
  localparam int VPSC_EV_DP_HPD_DN  = 3;
  localparam int VPSC_EV_CAP_DONE   = 4;
  localparam int VPSC_EV_TRAIN_DONE = 5;
  localparam int VPSC_EV_CEC_FALL   = 6;
  localparam int VPSC_EV_DDC_SCL    = 7;
  localparam int VPSC_EV_W          = 8;
  // Live status fields
  localparam int VPSC_ST_SRC_HPD  = 0;
  localparam int VPSC_ST_DP_HPD   = 1;
  localparam int VPSC_ST_VIDEO    = 2;
  localparam int VPSC_ST_LINK_UP  = 3;
  localparam int VPSC_ST_HP_ASSERT = 4;
  localparam int VPSC_ST_CEC      = 5;
  localparam int VPSC_ST_CHAN_LSB = 8;
  localparam int VPSC_ST_W        = 12;
  localparam logic [3:0] VPSC_TMDS_CHANNELS = 4'h3;
  // Source port sequence
  typedef enum logic [2:0] {
    VPSC_SRC_IDLE  = 3'b001,
    VPSC_SRC_QUERY = 3'b010,
    VPSC_SRC_VIDEO = 3'b100
  } vpsc_src_t;
  // DisplayPort link sequence
  typedef enum logic [2:0] {
    VPSC_DP_IDLE  = 3'b001,
    VPSC_DP_TRAIN = 3'b010,
    VPSC_DP_UP    = 3'b100
  } vpsc_dp_t;
endpackage : vpsc_pkg

// *** hdl/vpsc_sync.sv ***
// Two-stage synchroniser with edge pulses for a group of pin inputs.
// Assumes the inputs are asynchronous to clk; edges compare the second stage with a third register, prev_r.
`timescale 1ns/1ns
module vpsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Pins
  input  wire logic [W-1:0] pin_in,
  // Synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  // Edges are held off until prev_r holds a real pin sample, so idle-high pins give no false edge
  localparam int FILL = 3;
  logic [FILL-1:0] fill_r;
  wire  [W-1:0]    edge_ok = {W{fill_r[FILL-1]}};

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      fill_r <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[FILL-2:0], 1'b1};
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r & edge_ok;
  assign fall  = ~sync_r & prev_r & edge_ok;
endmodule : vpsc_sync

// *** verification/vpsc_far_end.sv ***
// Far-side equipment: display on the output port, video source on the input port, DisplayPort sink.
// Assumes the bench sets the attach and frame controls; DDC and CEC wires have pull-ups.
`timescale 1ns/1ns
module vpsc_far_end (
  // Bench controls
  input  wire logic disp_on,
  input  wire logic dp_on,
  input  wire logic ddc_go,
  // Device pulls
  input  wire logic sda_oe,
  input  wire logic cec_oe,
  // Wires seen by the device
  output logic      src_hpd,
  output logic      dp_hpd,
  output logic      scl,
  output logic      sda,
  output logic      cec
);
  logic m_low;

  assign src_hpd = disp_on;
  assign dp_hpd  = dp_on;
  // Open drain: any party pulling low beats the pull-up
  assign sda     = ~(sda_oe | m_low);
  assign cec     = ~cec_oe;
  ////////////////////////////////////////////////////////////////////////////////
  // The source masters the DDC clock, which stands high between frames
  initial
  begin
    scl   = 1'b1;
    m_low = 1'b0;
    forever
    begin
      wait (ddc_go);
      #3;
      repeat (9)
      begin
        #40 scl = 1'b0;
        m_low = ~m_low;
        #40 scl = 1'b1;
      end
      m_low = 1'b0;
    end
  end
endmodule : vpsc_far_end

// *** verification/test_video_port_sideband_control.sv ***
// Self-checking bench for the video port sideband control block.
// Assumes the far-side model vpsc_far_end and a 125 MHz core clock.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("BAD %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module test_video_port_sideband_control;
  import vpsc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} vpsc_row_t;
  logic        core_clk, nrst, reg_wr, reg_rd, irq, input_buffer_drive_enable, hot_plug_assert_out;
  logic        sink_ddc_scl_in, sink_ddc_sda_in, sink_ddc_sda_out, sink_ddc_sda_oe, cec_in, cec_out, cec_oe;
  logic        src_hpd_in, dp_hpd_in, ddc_responder_ready, ddc_responder_sda_low, ddc_scl_sync, ddc_sda_sync;
  logic        cap_query_start, cap_query_done, video_enable, dp_train_start, dp_train_done, dp_link_up;
  logic        dp_rate_high, disp_on, dp_on, ddc_go;
  logic [1:0]  dp_lane_count;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int          error_cnt, check_count, n;
  vpsc_row_t   rows [7];

  vpsc_top i_dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .input_buffer_drive_enable, .hot_plug_assert_out, .sink_ddc_scl_in, .sink_ddc_sda_in, .sink_ddc_sda_out,
    .sink_ddc_sda_oe, .cec_in, .cec_out, .cec_oe, .src_hpd_in, .dp_hpd_in, .ddc_responder_ready,
    .ddc_responder_sda_low, .ddc_scl_sync, .ddc_sda_sync, .cap_query_start, .cap_query_done, .video_enable,
    .dp_train_start, .dp_train_done, .dp_link_up, .dp_lane_count, .dp_rate_high);
  vpsc_far_end i_far (.disp_on, .dp_on, .ddc_go, .sda_oe(sink_ddc_sda_oe), .cec_oe,
    .src_hpd(src_hpd_in), .dp_hpd(dp_hpd_in), .scl(sink_ddc_scl_in), .sda(sink_ddc_sda_in), .cec(cec_in));

  initial
  begin
    core_clk = 1'b0;
    forever
      #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick
  // Bounded wait for a start pulse, counting cycles from the pin change
  task automatic wait_start(input bit dp);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while ((dp ? dp_train_start : cap_query_start) !== 1'b1 && n < 20);
  endtask : wait_start
  task automatic pulse_done(input bit dp);
    @(posedge core_clk);
    if (dp)
      dp_train_done <= 1'b1;
    else
      cap_query_done <= 1'b1;
    @(posedge core_clk);
    dp_train_done  <= 1'b0;
    cap_query_done <= 1'b0;
    tick(2);
  endtask : pulse_done
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ddc_responder_ready, ddc_responder_sda_low, cap_query_done, dp_train_done} = '0;
    {disp_on, dp_on, ddc_go} = '0;
    rows = '{'{VPSC_OFS_IMASK, 32'hffffffff, 32'hff}, '{VPSC_OFS_LINK, 32'h0, 32'h1},
      '{VPSC_OFS_LINK, 32'h3, 32'h2}, '{VPSC_OFS_LINK, 32'h6, 32'h6}, '{VPSC_OFS_LINK, 32'h5, 32'h5},
      '{8'h14, 32'hffffffff, 32'h0}, '{VPSC_OFS_CTRL, 32'hffffffe1, 32'h1}};
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    reg_read(VPSC_OFS_CTRL, rv);
    `CHK("ctrl_rst", 32'h0, rv)
    `CHK("drv_en_rst", 1'b0, input_buffer_drive_enable)
    `CHK("lane_rst", 2'h1, dp_lane_count)
    reg_read(VPSC_OFS_STAT, rv);
    `CHK("tmds_chan", 4'h3, rv[11:8])
    // Clear the status; edge masking leaves no events from the synchronisers filling after reset
    reg_read(VPSC_OFS_ISTAT, rv);
    $display("test reset done");
    foreach (rows[i])
    begin
      reg_write(rows[i].a, rows[i].d);
      reg_read(rows[i].a, rv);
      `CHK("row", rows[i].e, rv)
      if (rows[i].a === VPSC_OFS_LINK)
        `CHK("link_pins", rows[i].e[2:0], {dp_rate_high, dp_lane_count})
    end
    $display("test rows done");
    `CHK("drv_en", 1'b1, input_buffer_drive_enable)
    reg_write(VPSC_OFS_CTRL, 32'h3);
    tick(1);
    `CHK("hpa_unready", 1'b0, hot_plug_assert_out)
    @(posedge core_clk);
    ddc_responder_ready <= 1'b1;
    tick(1);
    `CHK("hpa_ready", 1'b1, hot_plug_assert_out)
    reg_write(VPSC_OFS_CTRL, 32'h7);
    tick(4);
    `CHK("cec_drive", 2'b10, {cec_oe, cec_out})
    reg_read(VPSC_OFS_ISTAT, rv);
    `CHK("cec_fall", 32'h40, rv)
    $display("test pins done");
    reg_write(VPSC_OFS_CTRL, 32'hb);
    @(posedge core_clk);
    disp_on <= 1'b1;
    wait_start(1'b0);
    `CHK("hpd_sync", 1'b1, n >= 2 && n < 20)
    tick(5);
    `CHK("video_early", 1'b0, video_enable)
    `CHK("irq_hpd", 1'b1, irq)
    pulse_done(1'b0);
    `CHK("video_on", 1'b1, video_enable)
    reg_read(VPSC_OFS_ISTAT, rv);
    `CHK("src_ev", 32'h11, rv)
    tick(1);
    `CHK("irq_clr", 1'b0, irq)
    @(posedge core_clk);
    disp_on <= 1'b0;
    tick(5);
    `CHK("video_off", 1'b0, video_enable)
    $display("test source done");
    reg_write(VPSC_OFS_CTRL, 32'h13);
    @(posedge core_clk);
    dp_on <= 1'b1;
    wait_start(1'b1);
    `CHK("dp_sync", 1'b1, n >= 2 && n < 20)
    `CHK("dp_early", 1'b0, dp_link_up)
    pulse_done(1'b1);
    `CHK("dp_up", 1'b1, dp_link_up)
    reg_write(VPSC_OFS_IMASK, 32'h0);
    @(posedge core_clk);
    dp_on <= 1'b0;
    tick(6);
    `CHK("dp_down", 1'b0, dp_link_up)
    `CHK("irq_mask", 1'b0, irq)
    reg_read(VPSC_OFS_ISTAT, rv);
    `CHK("dp_ev", 32'h2e, rv)
    $display("test link done");
    @(posedge core_clk);
    ddc_responder_sda_low <= 1'b1;
    tick(4);
    `CHK("sda_drive", 2'b10, {sink_ddc_sda_oe, sink_ddc_sda_out})
    `CHK("sda_sync", 1'b0, ddc_sda_sync)
    @(posedge core_clk);
    ddc_responder_sda_low <= 1'b0;
    ddc_go <= 1'b1;
    tick(20);
    @(posedge core_clk);
    ddc_go <= 1'b0;
    tick(100);
    `CHK("scl_idle", 1'b1, ddc_scl_sync)
    reg_read(VPSC_OFS_ISTAT, rv);
    `CHK("scl_ev", 1'b1, rv[7])
    $display("test ddc done");
    // Reset in mid-run: settings fall back and idle-high pins leave no edge events
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    tick(4);
    `CHK("drv_en_rerst", 1'b0, input_buffer_drive_enable)
    `CHK("rate_rerst", 1'b0, dp_rate_high)
    `CHK("lane_rerst", 2'h1, dp_lane_count)
    `CHK("hpa_rerst", 1'b0, hot_plug_assert_out)
    reg_read(VPSC_OFS_ISTAT, rv);
    `CHK("istat_rerst", 32'h0, rv)
    $display("test midrun reset done");
    wrap_up();
  end
endmodule : test_video_port_sideband_control
